// File: rtl/acrp_pkg.sv
// constants, types and state layout of the parallel convert/read port
// assumes: one 100 MHz clock, synchronous active-high reset
package acrp_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int RES_W  = 12;
  localparam int CHAN_W = 2;
  localparam int BYTE_W = 8;

  // ****************************************
  // conversion clock edge counts
  // ****************************************
  localparam logic [3:0] CONV_FALL_EDGES = 4'hE; // falls to end conversion
  localparam logic [3:0] TRACK_RISE_EDGE = 4'hD; // rise that ends hold

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int ACQ_TIME_NS   = 125;
  localparam int ACQ_CYCLES    =
    (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // power modes and sequencer setting
  // ****************************************
  localparam logic [1:0] PM_NORMAL        = 2'h0;
  localparam logic [1:0] PM_AUTO_SHUTDOWN = 2'h1;
  localparam logic [1:0] PM_AUTO_STANDBY  = 2'h2;
  localparam logic [1:0] PM_FULL_SHUTDOWN = 2'h3;
  localparam logic [1:0] SEQ_CONSECUTIVE  = 2'h3;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [RES_W-1:0]  RESULT_RESET  = 12'h000;
  localparam logic [CHAN_W-1:0] CHANNEL_RESET = 2'h0;
  localparam logic [3:0]        COUNT_RESET   = 4'h0;

  typedef enum logic [1:0]
  {
    ACRP_AWAIT_RISE,
    ACRP_TRACK,
    ACRP_CONVERT,
    ACRP_FINISH
  } acrp_phase_t;

  typedef struct packed
  {
    acrp_phase_t       phase;
    logic [3:0]        fall_count;
    logic [3:0]        rise_count;
    logic              hold;
    logic [RES_W-1:0]  result;
    logic [CHAN_W-1:0] chan_id;
    logic [CHAN_W-1:0] channel;
    logic [CHAN_W-1:0] conv_channel;
    logic              powered_down;
    logic              power_up;
    logic              internal_ref;
    logic [RES_W-1:0]  data_out;
    logic              data_oe;
  } acrp_state_t;

endpackage

// File: rtl/acrp_edge_if.sv
// edge detect carrier between the port and its edge detectors
// assumes: detector and user share one clock
`timescale 1ns/1ns
interface acrp_edge_if;
  logic level;
  logic rise;
  logic fall;

  modport det
  (
    input  level,
    output rise,
    output fall
  );
  modport user
  (
    output level,
    input  rise,
    input  fall
  );
endinterface

// File: rtl/acrp_edge.sv
// rise/fall detector on a synchronous level
// assumes: level already synchronous to clock
`timescale 1ns/1ns
module acrp_edge #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input  wire logic  clock,
  input  wire logic  rst,
  acrp_edge_if.det   edge_port
);
  typedef struct packed
  {
    logic prev;
  } acrp_edge_state_t;

  acrp_edge_state_t s;
  acrp_edge_state_t next_s;

  // remember last level
  always_comb
  begin
    next_s.prev = edge_port.level;
  end

  // reset value masks a spurious edge at release
  always_ff @(posedge clock)
  begin
    if (rst)
      s.prev <= RESET_LEVEL;
    else
      s <= next_s;
  end

  // edges from current level against last
  assign edge_port.rise = edge_port.level & ~s.prev;
  assign edge_port.fall = ~edge_port.level & s.prev;
endmodule

// File: rtl/acrp_port.sv
// conversion control and result read port of a 12-bit sampling converter
// assumes: all pins synchronous to clock; analog core supplies result_in
`timescale 1ns/1ns
module acrp_port
(
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire logic                        convert_strobe_n,
  input  wire logic                        conversion_clock_in,
  input  wire logic                        cs_n,
  input  wire logic                        rd_n,
  input  wire logic                        word_mode,
  input  wire logic                        data8_or_byte_select_pin_in,
  output logic                             data8_or_byte_select_pin_out,
  output logic                             data8_or_byte_select_pin_oe,
  output logic [acrp_pkg::RES_W-1:0]       data_out,
  output logic                             data_oe,
  output logic                             busy,
  output logic                             sample_hold,
  input  wire logic                        ref_select,
  output logic                             use_internal_ref,
  input  wire logic [1:0]                  power_mode,
  output logic                             powered_down,
  output logic                             power_up_start,
  input  wire logic                        sequence_cfg_bit0,
  input  wire logic                        sequence_cfg_bit1,
  input  wire logic [acrp_pkg::CHAN_W-1:0] channel_addr,
  input  wire logic                        ctrl_write,
  output logic [acrp_pkg::CHAN_W-1:0]      channel_select,
  input  wire logic [acrp_pkg::RES_W-1:0]  result_in
);
  import acrp_pkg::*;

  acrp_state_t s;
  acrp_state_t next_s;
  logic        read_active;
  logic        high_byte_select;
  logic        seq_mode;
  logic        auto_mode;

  // ****************************************
  // edge detectors
  // ****************************************
  acrp_edge_if strobe ();
  acrp_edge_if cclk ();

  assign strobe.level = convert_strobe_n;
  assign cclk.level   = conversion_clock_in;

  acrp_edge #(.RESET_LEVEL(1'b1)) strobe_edge
  (
    .clock     (clock),
    .rst       (rst),
    .edge_port (strobe)
  );

  acrp_edge #(.RESET_LEVEL(1'b0)) cclk_edge
  (
    .clock     (clock),
    .rst       (rst),
    .edge_port (cclk)
  );

  // ****************************************
  // decodes
  // ****************************************
  assign read_active = ~cs_n & ~rd_n;
  assign high_byte_select = ~word_mode & data8_or_byte_select_pin_in;
  assign seq_mode = ({sequence_cfg_bit1, sequence_cfg_bit0}
                     == SEQ_CONSECUTIVE);
  assign auto_mode = (power_mode == PM_AUTO_SHUTDOWN) |
                     (power_mode == PM_AUTO_STANDBY);

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    next_s = s;
    next_s.power_up = 1'b0;
    next_s.internal_ref = ref_select;
    unique case (s.phase)
      ACRP_AWAIT_RISE:
      begin
        // sampler sits in hold until the first strobe rise
        if (strobe.rise)
        begin
          next_s.phase = ACRP_TRACK;
          next_s.hold  = 1'b0;
        end
      end
      ACRP_TRACK:
      begin
        if (strobe.fall && !s.powered_down)
        begin
          next_s.phase        = ACRP_CONVERT;
          next_s.hold         = 1'b1;
          next_s.fall_count   = COUNT_RESET;
          next_s.rise_count   = COUNT_RESET;
          next_s.conv_channel = s.channel;
        end
      end
      ACRP_CONVERT:
      begin
        if (cclk.rise)
        begin
          next_s.rise_count = s.rise_count + 4'h1;
          if (s.rise_count + 4'h1 == TRACK_RISE_EDGE)
            next_s.hold = 1'b0;
        end
        if (cclk.fall && (s.fall_count + 4'h1 == CONV_FALL_EDGES))
        begin
          next_s.phase   = ACRP_FINISH;
          next_s.result  = result_in;
          next_s.chan_id = s.conv_channel;
        end
        else if (strobe.rise)
        begin
          next_s.phase = ACRP_TRACK;
          next_s.hold  = 1'b0;
        end
        else if (cclk.fall)
          next_s.fall_count = s.fall_count + 4'h1;
      end
      ACRP_FINISH:
      begin
        next_s.phase = ACRP_TRACK;
        if (auto_mode)
        begin
          next_s.powered_down = 1'b1;
          next_s.hold         = 1'b1;
        end
        if (seq_mode)
          next_s.channel = (s.channel == channel_addr)
                           ? CHANNEL_RESET
                           : s.channel + 2'h1;
      end
    endcase
    // wake from auto power-down on strobe rise
    if (s.powered_down && auto_mode && strobe.rise)
    begin
      next_s.powered_down = 1'b0;
      next_s.power_up     = 1'b1;
      next_s.hold         = 1'b0;
    end
    // full shutdown holds until the mode returns to normal
    if (power_mode == PM_FULL_SHUTDOWN && s.phase == ACRP_TRACK)
    begin
      next_s.powered_down = 1'b1;
      next_s.hold         = 1'b1;
    end
    else if (power_mode == PM_NORMAL && s.powered_down)
    begin
      next_s.powered_down = 1'b0;
      next_s.hold         = 1'b0;
    end
    // control write restarts channel selection
    if (ctrl_write)
      next_s.channel = seq_mode ? CHANNEL_RESET : channel_addr;
    // read data from the newest result
    next_s.data_oe = read_active;
    if (read_active)
    begin
      if (word_mode)
        next_s.data_out = next_s.result;
      else if (high_byte_select)
        next_s.data_out = {4'h0, 2'h0, next_s.chan_id,
                           next_s.result[RES_W-1:BYTE_W]};
      else
        next_s.data_out = {4'h0, next_s.result[BYTE_W-1:0]};
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s.phase        <= ACRP_AWAIT_RISE;
      s.fall_count   <= COUNT_RESET;
      s.rise_count   <= COUNT_RESET;
      s.hold         <= 1'b1;
      s.result       <= RESULT_RESET;
      s.chan_id      <= CHANNEL_RESET;
      s.channel      <= CHANNEL_RESET;
      s.conv_channel <= CHANNEL_RESET;
      s.powered_down <= 1'b0;
      s.power_up     <= 1'b0;
      s.internal_ref <= 1'b0;
      s.data_out     <= RESULT_RESET;
      s.data_oe      <= 1'b0;
    end
    else
      s <= next_s;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign busy = (s.phase == ACRP_CONVERT) | (s.phase == ACRP_FINISH);
  assign sample_hold      = s.hold;
  assign use_internal_ref = s.internal_ref;
  assign powered_down     = s.powered_down;
  assign power_up_start   = s.power_up;
  assign channel_select   = s.channel;
  assign data_out         = s.data_out;
  assign data_oe          = s.data_oe;
  // shared pin is a data line only in word mode
  assign data8_or_byte_select_pin_out = s.data_out[BYTE_W];
  assign data8_or_byte_select_pin_oe  = s.data_oe & word_mode;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  start_busy_a: assert property (
    s.phase == ACRP_TRACK && strobe.fall && !s.powered_down
    |=> busy && sample_hold)
    else $error("conversion did not start on strobe fall");

  abort_track_a: assert property (
    s.phase == ACRP_CONVERT && strobe.rise && !cclk.fall
    |=> !busy && !sample_hold)
    else $error("early strobe rise did not abort");

  busy_end_a: assert property (
    s.phase == ACRP_FINISH |=> !busy)
    else $error("busy did not fall after conversion");

  first_rise_a: assert property (
    s.phase == ACRP_AWAIT_RISE && !strobe.rise |=> sample_hold)
    else $error("sampler left hold before first strobe rise");

  track_after_a: assert property (
    busy && cclk.rise && s.rise_count == TRACK_RISE_EDGE - 4'h1
    |=> !sample_hold)
    else $error("hold not released on 13th rise");

  wake_pulse_a: assert property (
    powered_down && auto_mode && strobe.rise
    |=> power_up_start && !powered_down ##1 !power_up_start)
    else $error("no power-up on strobe rise");

  ref_follow_a: assert property (
    ref_select |=> use_internal_ref)
    else $error("reference select not applied");

  ref_external_a: assert property (
    !ref_select |=> !use_internal_ref)
    else $error("external reference not applied");

  oe_follow_a: assert property (
    data_oe == $past(read_active))
    else $error("bus enable does not follow chip select and read");

  word_read_a: assert property (
    read_active && word_mode |=> data_oe && data_out == s.result)
    else $error("word read wrong");

  high_byte_a: assert property (
    read_active && high_byte_select
    |=> data_out[7:6] == 2'h0 && data_out[5:4] == s.chan_id)
    else $error("high byte layout wrong");

  bus_release_a: assert property (
    $rose(rd_n) && $past(read_active) |-> data_oe ##1 !data_oe)
    else $error("bus not held then released");

  early_data_a: assert property (
    $past(read_active) && $past(word_mode) && s.phase == ACRP_FINISH
    |-> data_out == s.result)
    else $error("result not on bus before busy falls");

  seq_wrap_a: assert property (
    s.phase == ACRP_FINISH && seq_mode && !ctrl_write
    && s.channel == channel_addr |=> channel_select == CHANNEL_RESET)
    else $error("sequence did not wrap");

  conv_done_c: cover property (s.phase == ACRP_FINISH ##1 !busy);
  abort_c: cover property (busy ##1 strobe.rise ##1 !busy);
  byte_pair_c: cover property (
    read_active && !word_mode && !high_byte_select
    ##[1:20] read_active && high_byte_select);
  wake_c: cover property (power_up_start);

endmodule

// File: sim/acrp_clk_model.sv
// host-side source of the conversion clock
// assumes: bench clock; run gates the clock, which drops low on the first bench clock edge that samples run cleared
`timescale 1ns/1ns
module acrp_clk_model
(
  input  wire logic       clock,
  input  wire logic       run,
  input  wire logic [3:0] half,
  output logic            conv_clk
);
  logic [3:0] cnt;

  // toggle every half+1 cycles, stand still low between frames
  always_ff @(posedge clock)
  begin
    if (!run)
    begin
      cnt      <= 4'h0;
      conv_clk <= 1'b0;
    end
    else if (cnt == half)
    begin
      cnt      <= 4'h0;
      conv_clk <= ~conv_clk;
    end
    else
      cnt <= cnt + 4'h1;
  end
endmodule

// File: sim/tb_adc_parallel_convert_read_port.sv
// self-checking bench of the parallel convert/read port
// assumes: acrp_pkg compiled; clock model drives the conversion clock
`timescale 1ns/1ns
module tb_adc_parallel_convert_read_port;
  import acrp_pkg::*;

  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        convert_strobe_n = 1'b1;
  logic        cs_n = 1'b1;
  logic        rd_n = 1'b1;
  logic        word_mode = 1'b1;
  logic        pin_drv = 1'b0;
  logic        ref_select = 1'b0;
  logic [1:0]  power_mode = 2'h0;
  logic [1:0]  seq_cfg = 2'h0;
  logic [1:0]  channel_addr = 2'h0;
  logic        ctrl_write = 1'b0;
  logic [11:0] result_in = 12'h000;
  logic        run = 1'b0;
  logic [3:0]  half = 4'h1;
  logic        conv_clk;
  logic        pin_w;
  logic        pin_out;
  logic        pin_oe;
  logic [11:0] data_out;
  logic        data_oe;
  logic        busy;
  logic        sample_hold;
  logic        use_internal_ref;
  logic        powered_down;
  logic        power_up_start;
  logic [1:0]  channel_select;
  int          miscompares = 0;
  int          n_checks = 0;

  always #5 clock = ~clock;
  // shared pin: the port wins while it drives
  assign pin_w = pin_oe ? pin_out : pin_drv;

  acrp_clk_model clk_u
  (
    .clock    (clock),
    .run      (run),
    .half     (half),
    .conv_clk (conv_clk)
  );

  acrp_port dut_u
  (
    .clock                        (clock),
    .rst                          (rst),
    .convert_strobe_n             (convert_strobe_n),
    .conversion_clock_in          (conv_clk),
    .cs_n                         (cs_n),
    .rd_n                         (rd_n),
    .word_mode                    (word_mode),
    .data8_or_byte_select_pin_in  (pin_w),
    .data8_or_byte_select_pin_out (pin_out),
    .data8_or_byte_select_pin_oe  (pin_oe),
    .data_out                     (data_out),
    .data_oe                      (data_oe),
    .busy                         (busy),
    .sample_hold                  (sample_hold),
    .ref_select                   (ref_select),
    .use_internal_ref             (use_internal_ref),
    .power_mode                   (power_mode),
    .powered_down                 (powered_down),
    .power_up_start               (power_up_start),
    .sequence_cfg_bit0            (seq_cfg[0]),
    .sequence_cfg_bit1            (seq_cfg[1]),
    .channel_addr                 (channel_addr),
    .ctrl_write                   (ctrl_write),
    .channel_select               (channel_select),
    .result_in                    (result_in)
  );

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    if (miscompares == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // fl: busy seen, hold ended in busy, result shown in busy
  task automatic conv(input logic [11:0] res, output logic [2:0] fl);
    fl = 3'h0;
    result_in        <= res;
    convert_strobe_n <= 1'b1;
    tick(ACQ_CYCLES + 2);
    convert_strobe_n <= 1'b0;
    run              <= 1'b1;
    for (int i = 0; i < 400; i++)
    begin
      tick(1);
      if (busy === 1'b1) fl[2] = 1'b1;
      if (busy === 1'b1 && sample_hold === 1'b0) fl[1] = 1'b1;
      if (busy === 1'b1 && data_out === res) fl[0] = 1'b1;
      if (fl[2] && busy !== 1'b1) break;
    end
    run <= 1'b0;
  endtask

  // one read access, returns data and {pin_oe, pin_out}
  task automatic rd(input logic wm, input logic sel,
                    output logic [11:0] d, output logic [1:0] p);
    word_mode <= wm;
    pin_drv   <= sel;
    cs_n      <= 1'b0;
    rd_n      <= 1'b0;
    tick(3);
    d = data_out;
    p = {pin_oe, pin_out};
    chk({11'h0, data_oe}, 12'h001);
    rd_n <= 1'b1;
    cs_n <= 1'b1;
    tick(3);
    chk({11'h0, data_oe}, 12'h000);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_init;
    chk({11'h0, sample_hold}, 12'h001);
    convert_strobe_n <= 1'b0;
    tick(4);
    chk({11'h0, busy}, 12'h000);
    convert_strobe_n <= 1'b1;
    tick(4);
    chk({11'h0, sample_hold}, 12'h000);
  endtask

  task automatic t_ref;
    ref_select <= 1'b1;
    tick(3);
    chk({11'h0, use_internal_ref}, 12'h001);
    ref_select <= 1'b0;
    tick(3);
    chk({11'h0, use_internal_ref}, 12'h000);
  endtask

  task automatic t_word;
    logic [2:0]  fl;
    logic [11:0] d;
    logic [1:0]  p;
    channel_addr <= 2'h2;
    ctrl_write   <= 1'b1;
    tick(1);
    ctrl_write <= 1'b0;
    conv(12'hA5C, fl);
    chk({11'h0, fl[2]}, 12'h001);
    chk({11'h0, fl[1]}, 12'h001);
    chk({11'h0, busy}, 12'h000);
    rd(1'b1, 1'b0, d, p);
    chk(d, 12'hA5C);
    chk({10'h0, p}, 12'h002);
    rd(1'b0, 1'b0, d, p);
    chk(d, 12'h05C);
    chk({11'h0, p[1]}, 12'h000);
    rd(1'b0, 1'b1, d, p);
    chk(d, 12'h02A);
  endtask

  task automatic t_abort;
    convert_strobe_n <= 1'b1;
    tick(ACQ_CYCLES + 2);
    convert_strobe_n <= 1'b0;
    run              <= 1'b1;
    tick(10);
    chk({11'h0, busy}, 12'h001);
    convert_strobe_n <= 1'b1;
    run              <= 1'b0;
    tick(4);
    chk({11'h0, busy}, 12'h000);
    chk({11'h0, sample_hold}, 12'h000);
  endtask

  task automatic t_cont;
    logic [2:0] fl;
    word_mode <= 1'b1;
    cs_n      <= 1'b0;
    rd_n      <= 1'b0;
    conv(12'h3C7, fl);
    chk({11'h0, fl[0]}, 12'h001);
    chk({11'h0, data_oe}, 12'h001);
    chk(data_out, 12'h3C7);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    tick(2);
  endtask

  task automatic t_power;
    logic [2:0] fl;
    logic       pu;
    // autoshutdown then autostandby
    for (int m = 1; m < 3; m++)
    begin
      pu = 1'b0;
      power_mode <= 2'(m);
      conv(12'h111, fl);
      tick(2);
      chk({11'h0, powered_down}, 12'h001);
      convert_strobe_n <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
        tick(1);
        if (power_up_start === 1'b1) pu = 1'b1;
      end
      chk({11'h0, pu}, 12'h001);
      chk({11'h0, powered_down}, 12'h000);
    end
    // full shutdown holds until the mode returns to normal
    power_mode <= PM_FULL_SHUTDOWN;
    tick(3);
    chk({11'h0, powered_down}, 12'h001);
    chk({11'h0, sample_hold}, 12'h001);
    power_mode <= PM_NORMAL;
    tick(3);
    chk({11'h0, powered_down}, 12'h000);
    chk({11'h0, sample_hold}, 12'h000);
  endtask

  task automatic t_seq;
    logic [2:0] fl;
    half         <= 4'h3;
    seq_cfg      <= SEQ_CONSECUTIVE;
    channel_addr <= 2'h1;
    ctrl_write   <= 1'b1;
    tick(1);
    ctrl_write <= 1'b0;
    for (int k = 0; k < 3; k++)
    begin
      tick(2);
      chk({10'h0, channel_select}, 12'(k % 2));
      conv(12'h0F0, fl);
    end
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial
  begin
    tick(4);
    rst <= 1'b0;
    tick(2);
    t_init;
    t_ref;
    t_word;
    t_abort;
    t_cont;
    t_power;
    t_seq;
    summarize;
  end

  initial
  begin
    #50000;
    miscompares++;
    summarize;
  end
endmodule
